/* rtl/rpm_pkg.sv */
// Constants shared by the receive power meter result bank.
// Assumes a byte-wide register read port addressed by 10-bit register offsets.
`default_nettype none
package rpm_pkg;
   // Register offsets
   localparam logic [9:0] RPM_OFS_I_33_26 = 10'h186;
   localparam logic [9:0] RPM_OFS_I_25_18 = 10'h187;
   localparam logic [9:0] RPM_OFS_I_17_10 = 10'h188;
   localparam logic [9:0] RPM_OFS_I_9_2 = 10'h189;
   localparam logic [9:0] RPM_OFS_IQ_MIX = 10'h18A;
   localparam logic [9:0] RPM_OFS_Q_51_44 = 10'h18B;
   localparam logic [9:0] RPM_OFS_Q_43_36 = 10'h18C;
   localparam logic [9:0] RPM_OFS_Q_35_28 = 10'h18D;
   localparam logic [9:0] RPM_OFS_Q_27_20 = 10'h18E;
   localparam logic [9:0] RPM_OFS_Q_19_12 = 10'h18F;
   localparam logic [9:0] RPM_OFS_Q_11_4 = 10'h190;
   localparam logic [9:0] RPM_OFS_Q_LOW_RDY = 10'h191;
   localparam logic [9:0] RPM_OFS_COARSE = 10'h1B2;
   // Field positions
   localparam int RPM_RDY_I_BIT = 0;
   localparam int RPM_RDY_Q_BIT = 1;
   localparam int RPM_COARSE_I_LSB = 4;
   localparam int RPM_COARSE_Q_LSB = 0;
   // Widths and reset values
   localparam int RPM_FINE_W = 58;
   localparam int RPM_CNT_W = 21;
   localparam logic [7:0] RPM_RESET_VAL = 8'h00;
   localparam logic [3:0] RPM_COARSE_MAX = 4'hF;
   // Result phase of the meter
   typedef enum logic [2:0]
   {
      RPM_IDLE = 3'b001,
      RPM_INTEG = 3'b010,
      RPM_LATCH = 3'b100
   } rpm_state_t;
endpackage : rpm_pkg
`default_nettype wire

/* rtl/rpm_result_regs.sv */
// Result register bank of the receive power meter, with the integrator that feeds it.
// Assumes samples synchronous to ref_clk and a register port that reads one byte per offset.
`default_nettype none

// How it works
// R1 - I fine result holds I power in real mode, I^2+Q^2 in complex.
// R2 - Q fine result holds Q power in real mode, meaningless in complex.
// R3 - Software may read only bits 57:8; low eight bits carry nothing. The code maps I[33:0] and Q[57:0], low bits included, into 0x186-0x191.
// R4 - I ready flag, bit 0 at 0x191, sets after first I computation.
// R5 - Q ready flag, bit 1 at 0x191, sets after first Q computation.
// R6 - Coarse Q code sits in low nibble of 0x1B2.
// R7 - Coarse I code sits in high nibble; complex power there in complex mode.
// R8 - Complex mode scales against twice the real full scale.
// R9 - Code k means above -(16-k) dBFS; zero means below -15 dBFS.
// R10 - Fine results packed MSB-first; 0x18A holds I[1:0] and Q[57:52].
// R11 - Lowest Q bits sit in upper 0x191 beside the ready flags.
// R12 - Result registers are read-only and reset to zero.
// R13 - Resolution select clear gives linear fine, set gives coarse dB.
// R14 - Real/complex select clear gives separate squares, set gives their sum.
// R15 - Fine integration spans 8N+3 samples, N the 21-bit count.
// R16 - Results update only on completion and hold until replaced.
module rpm_result_regs
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Meter configuration
   input wire logic meter_enable,
   input wire logic meter_resolution_select,
   input wire logic meter_real_complex_select,
   input wire logic [rpm_pkg::RPM_CNT_W-1:0] integration_length_count,
   // Receive samples
   input wire logic sample_valid,
   input wire logic signed [11:0] sample_i,
   input wire logic signed [11:0] sample_q,
   // Register read port
   input wire logic [9:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Result status
   output logic i_result_ready_flag,
   output logic q_result_ready_flag,
   output logic result_update
);
   import rpm_pkg::*;

   typedef struct packed {
      rpm_state_t state;
      logic [23:0] count;
      logic [RPM_FINE_W-1:0] acc_i;
      logic [RPM_FINE_W-1:0] acc_q;
      logic [RPM_FINE_W-1:0] fine_i_power_result;
      logic [RPM_FINE_W-1:0] fine_q_power_result;
      logic [3:0] coarse_i_power_code;
      logic [3:0] coarse_q_power_code;
      logic rdy_i;
      logic rdy_q;
      logic upd;
      logic [7:0] rdata;
   } rpm_regs_t;

   rpm_regs_t st_reg;
   rpm_regs_t st_next;
   logic [23:0] samples_needed;
   logic [23:0] sq_i;
   logic [23:0] sq_q;
   logic [RPM_FINE_W-1:0] mean_i;
   logic [RPM_FINE_W-1:0] mean_q;

   // Code k set when power exceeds full scale times 10^((k-16)/10); thresholds as fractions of 2^22 units, 2^23 in complex
   function automatic logic [3:0] rpm_db_code(input logic [RPM_FINE_W-1:0] pwr, input logic cplx);
      logic [RPM_FINE_W-1:0] fs;
      logic [RPM_FINE_W-1:0] p;
      logic [3:0] code;
      fs = cplx ? 58'h0000000_0800000 : 58'h0000000_0400000;
      p = pwr;
      code = 4'h0;
      // Compare 64*p against fs*table, table entries are 64*10^(-n/10)
      if ((p << 6) > (fs * 58'd50)) code = 4'hF;
      else if ((p << 6) > (fs * 58'd40)) code = 4'hE;
      else if ((p << 6) > (fs * 58'd32)) code = 4'hD;
      else if ((p << 6) > (fs * 58'd25)) code = 4'hC;
      else if ((p << 6) > (fs * 58'd20)) code = 4'hB;
      else if ((p << 6) > (fs * 58'd16)) code = 4'hA;
      else if ((p << 6) > (fs * 58'd12)) code = 4'h9;
      else if ((p << 6) > (fs * 58'd10)) code = 4'h8;
      else if ((p << 6) > (fs * 58'd8)) code = 4'h7;
      else if ((p << 6) > (fs * 58'd6)) code = 4'h6;
      else if ((p << 6) > (fs * 58'd5)) code = 4'h5;
      else if ((p << 6) > (fs * 58'd4)) code = 4'h4;
      else if ((p << 6) > (fs * 58'd3)) code = 4'h3;
      else if ((p << 7) > (fs * 58'd5)) code = 4'h2;
      else if ((p << 6) > (fs * 58'd2)) code = 4'h1;
      return code;
   endfunction : rpm_db_code

   // Squares of the 12-bit samples, always non-negative
   // Operands widened first, so the product is formed at 24 bits and not cut to 12
   assign sq_i = 24'(sample_i) * 24'(sample_i);
   assign sq_q = 24'(sample_q) * 24'(sample_q);
   // R15 span length 8N+3
   assign samples_needed = 24'({integration_length_count, 3'b000}) + 24'h000003;
   // Coarse mode works on the mean power per sample, a trade of two dividers for exact scaling
   assign mean_i = st_reg.acc_i / RPM_FINE_W'(samples_needed);
   assign mean_q = st_reg.acc_q / RPM_FINE_W'(samples_needed);

   // Next-state logic for integration, result capture and reads
   always_comb
   begin
      st_next = st_reg;
      st_next.upd = 1'b0;
      case (st_reg.state)
         RPM_IDLE:
         begin
            if (meter_enable)
            begin
               st_next.state = RPM_INTEG;
               st_next.count = 24'h000000;
               st_next.acc_i = '0;
               st_next.acc_q = '0;
            end
         end
         RPM_INTEG:
         begin
            if (!meter_enable)
               st_next.state = RPM_IDLE;
            else if (sample_valid)
            begin
               // R14 separate squares or their sum
               if (meter_real_complex_select)
                  st_next.acc_i = st_reg.acc_i + RPM_FINE_W'(sq_i) + RPM_FINE_W'(sq_q);
               else
               begin
                  st_next.acc_i = st_reg.acc_i + RPM_FINE_W'(sq_i);
                  st_next.acc_q = st_reg.acc_q + RPM_FINE_W'(sq_q);
               end
               st_next.count = st_reg.count + 24'h000001;
               if (st_reg.count + 24'h000001 == samples_needed)
                  st_next.state = RPM_LATCH;
            end
         end
         RPM_LATCH:
         begin
            // R16 update only on completion
            // R13 fine linear or coarse dB
            if (!meter_resolution_select)
            begin
               // R1 I field carries I or complex power
               st_next.fine_i_power_result = st_reg.acc_i;
               // R2 Q field zero in complex mode
               st_next.fine_q_power_result = meter_real_complex_select ? '0 : st_reg.acc_q;
            end
            else
            begin
               // R9 dB code mapping
               // R8 doubled full scale
               // R7 I nibble or complex power
               st_next.coarse_i_power_code = rpm_db_code(mean_i, meter_real_complex_select);
               // R6 Q nibble meaningless in complex
               st_next.coarse_q_power_code = meter_real_complex_select ? 4'h0 :
                  rpm_db_code(mean_q, 1'b0);
            end
            // R4 first I result ready
            st_next.rdy_i = 1'b1;
            // R5 first Q result ready
            st_next.rdy_q = 1'b1;
            st_next.upd = 1'b1;
            st_next.state = RPM_INTEG;
            st_next.count = 24'h000000;
            st_next.acc_i = '0;
            st_next.acc_q = '0;
         end
         default:
            st_next.state = RPM_IDLE;
      endcase
      // R12 writes ignored, reg_wr and reg_wdata never change contents
      if (reg_rd)
      begin
         // R10 MSB-first byte packing
         // R3 low byte offered but carries nothing useful
         case (reg_addr)
            RPM_OFS_I_33_26: st_next.rdata = st_reg.fine_i_power_result[33:26];
            RPM_OFS_I_25_18: st_next.rdata = st_reg.fine_i_power_result[25:18];
            RPM_OFS_I_17_10: st_next.rdata = st_reg.fine_i_power_result[17:10];
            RPM_OFS_I_9_2: st_next.rdata = st_reg.fine_i_power_result[9:2];
            RPM_OFS_IQ_MIX: st_next.rdata = {st_reg.fine_i_power_result[1:0], st_reg.fine_q_power_result[57:52]};
            RPM_OFS_Q_51_44: st_next.rdata = st_reg.fine_q_power_result[51:44];
            RPM_OFS_Q_43_36: st_next.rdata = st_reg.fine_q_power_result[43:36];
            RPM_OFS_Q_35_28: st_next.rdata = st_reg.fine_q_power_result[35:28];
            RPM_OFS_Q_27_20: st_next.rdata = st_reg.fine_q_power_result[27:20];
            RPM_OFS_Q_19_12: st_next.rdata = st_reg.fine_q_power_result[19:12];
            RPM_OFS_Q_11_4: st_next.rdata = st_reg.fine_q_power_result[11:4];
            // R11 low Q bits above ready flags
            RPM_OFS_Q_LOW_RDY: st_next.rdata = {st_reg.fine_q_power_result[3:0], 2'b00,
               st_reg.rdy_q, st_reg.rdy_i};
            RPM_OFS_COARSE: st_next.rdata = {st_reg.coarse_i_power_code, st_reg.coarse_q_power_code};
            default: st_next.rdata = RPM_RESET_VAL;
         endcase
      end
   end

   // State register; R12 everything clears to zero except state, which loads RPM_IDLE
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.state <= RPM_IDLE;
      end
      else
         st_reg <= st_next;
   end

   assign reg_rdata = st_reg.rdata;
   assign i_result_ready_flag = st_reg.rdy_i;
   assign q_result_ready_flag = st_reg.rdy_q;
   assign result_update = st_reg.upd;
endmodule : rpm_result_regs
`default_nettype wire

/* dv/rpm_result_checker.sv */
// Port assertions for the power meter result bank.
// Assumes one clock with an active-low asynchronous reset.
`default_nettype none
module rpm_result_checker
(
   // Clock, reset and watched ports
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [9:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic i_result_ready_flag,
   input wire logic q_result_ready_flag,
   input wire logic result_update
);
   // Single domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   a_update_pulse: assert property (result_update |=> !result_update) else $error("long update");
   a_i_flag_sticky: assert property (i_result_ready_flag |=> i_result_ready_flag) else $error("I flag fell");
   a_q_flag_sticky: assert property (q_result_ready_flag |=> q_result_ready_flag) else $error("Q flag fell");
   a_i_flag_cause: assert property ($rose(i_result_ready_flag) |-> result_update) else $error("I flag early");
   a_q_flag_cause: assert property ($rose(q_result_ready_flag) |-> result_update) else $error("Q flag early");
   // only reads move the data; a hole reads zero
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("data moved");
   a_hole_zero: assert property (reg_rd && reg_addr == 10'h1A0 |=> reg_rdata == 8'h00) else $error("hole");
   a_flag_byte: assert property (reg_rd && reg_addr == 10'h191 |=>
      reg_rdata[3:0] == {2'b00, $past(q_result_ready_flag), $past(i_result_ready_flag)}) else $error("flag byte");
   // Main scenarios
   c_capture: cover property (result_update);
   c_flag_read: cover property (reg_rd && reg_addr == 10'h191 && q_result_ready_flag);
   c_coarse_read: cover property (reg_rd && reg_addr == 10'h1B2);
endmodule : rpm_result_checker
bind rpm_result_regs rpm_result_checker u_rpm_result_checker (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_result_ready_flag(i_result_ready_flag),
   .q_result_ready_flag(q_result_ready_flag), .result_update(result_update));
`default_nettype wire

/* dv/testbench.sv */
// Directed bench for the power meter result bank.
// Assumes the package, the bank and its checker are compiled first.
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rpm_pkg::*;
   logic ref_clk = 1'b0, rstn = 1'b0, meter_enable = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, sample_valid = 1'b1;
   logic meter_resolution_select = 1'b0, meter_real_complex_select = 1'b0;
   logic [RPM_CNT_W-1:0] integration_length_count = '0;
   logic signed [11:0] sample_i = '0, sample_q = '0;
   logic [9:0] reg_addr = '0;
   logic [7:0] reg_wdata = 8'hFF, reg_rdata;
   logic i_result_ready_flag, q_result_ready_flag, result_update;
   int fail_count = 0, checked = 0;
   // Clock at 100 MHz
   always #5 ref_clk = ~ref_clk;
   // Block under test
   rpm_result_regs u_rpm_result_regs
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .meter_enable(meter_enable),
      .meter_resolution_select(meter_resolution_select),
      .meter_real_complex_select(meter_real_complex_select),
      .integration_length_count(integration_length_count),
      .sample_valid(sample_valid),
      .sample_i(sample_i),
      .sample_q(sample_q),
      .reg_addr(reg_addr),
      .reg_rd(reg_rd),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .i_result_ready_flag(i_result_ready_flag),
      .q_result_ready_flag(q_result_ready_flag),
      .result_update(result_update)
   );
   // Counts, verdict, stop
   task automatic test_done(input logic hung = 1'b0);
      fail_count += int'(hung);
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   // Read a byte, maybe writing alongside; data lands one edge later
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic w = 1'b0);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_wr <= w;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask : rd
   // One span of steady samples; disabling right after capture drops the next partial span
   task automatic run(input logic [1:0] m, input logic [20:0] n, input logic [11:0] si, sq);
      int k;
      @(posedge ref_clk);
      {meter_resolution_select, meter_real_complex_select} <= m;
      integration_length_count <= n;
      sample_i <= si;
      sample_q <= sq;
      meter_enable <= 1'b1;
      for (k = 0; k < 300 && result_update !== 1'b1; k++) @(negedge ref_clk);
      if (k == 300) test_done(1'b1);
      @(posedge ref_clk);
      meter_enable <= 1'b0;
   endtask : run
   // Main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int a = 'h186; a <= 'h1B2; a++) rd(a[9:0], 8'h00);
      $display("test reset values done");
      // Real, 3 samples: I = 3*17*17 = 0x363, Q = 3*5*5 = 0x4B
      run(2'b00, 21'h0, 12'h011, 12'h005);
      rd(10'h189, 8'hD8);
      rd(10'h18A, 8'hC0, 1'b1);
      rd(10'h190, 8'h04);
      rd(10'h191, 8'hB3);
      // Software fetches only bits 57:8; the Q[19:12] byte at 0x18F of this small result is zero
      rd(10'h18F, 8'h00);
      rd(10'h18A, 8'hC0);
      // Complex, 11 samples: I = 11*314 = 0xD7E, Q cleared
      run(2'b01, 21'h1, 12'h011, 12'h005);
      rd(10'h188, 8'h03);
      rd(10'h18A, 8'h80);
      $display("test fine results done");
      // Coarse: 2047 sits near full scale; 1943 is near -3.5 dB of the doubled complex scale
      run(2'b10, 21'h0, 12'h7FF, 12'h000);
      rd(10'h1B2, 8'hF0);
      rd(10'h189, 8'h5F);
      run(2'b10, 21'h0, 12'h000, 12'h801);
      rd(10'h1B2, 8'h0F);
      run(2'b11, 21'h0, 12'h797, 12'h000);
      rd(10'h1B2, 8'hC0);
      $display("test coarse codes done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
